// File: src/dgv_pkg.sv
// Package with register map, field layout and timing constants of the gain and volume register bank
package dgv_pkg;
	localparam int          AddrW        = 7;
	localparam int          DataW        = 9;
	localparam logic [6:0]  OffLeftLow   = 7'h00;
	localparam logic [6:0]  OffLeftHigh  = 7'h01;
	localparam logic [6:0]  OffRightLow  = 7'h02;
	localparam logic [6:0]  OffRightHigh = 7'h03;
	localparam logic [6:0]  OffVolume    = 7'h04;
	localparam logic [6:0]  OffFormat    = 7'h05;
	localparam logic [6:0]  OffFilter    = 7'h06;
	localparam logic [6:0]  OffModeOne   = 7'h07;
	localparam logic [6:0]  OffModeTwo   = 7'h08;
	localparam logic [6:0]  OffSoftReset = 7'h09;
	localparam logic [6:0]  OffAddOne    = 7'h20;
	localparam logic [8:0]  RstZero      = 9'h000;
	localparam logic [8:0]  RstFormat    = 9'h00a;
	localparam logic [8:0]  RstModeTwo   = 9'h002;
	// Field positions
	localparam int          UpdateBit    = 5;
	localparam int          GlideBit     = 0;
	localparam int          CutBit       = 1;
	localparam int          FollowBit    = 2;
	localparam int          SilenceBit   = 3;
	localparam int          DetectBit    = 4;
	localparam int          ZeroSrcLo    = 5;
	localparam int          AnalogBit    = 7;
	localparam int          ResetBit     = 8;
	// Zero pin source codes
	localparam logic [1:0]  ZeroBoth     = 2'h0;
	localparam logic [1:0]  ZeroLeft     = 2'h1;
	localparam logic [1:0]  ZeroRight    = 2'h2;
	localparam logic [1:0]  ZeroOff      = 2'h3;
	// Mode codes in mode register one
	localparam logic [1:0]  ModePcm      = 2'h0;
	// Long zero run length, in samples
	localparam logic [10:0] ZeroRunLen   = 11'h400;
	// Serial frame: 7 address bits then 9 data bits
	localparam logic [4:0]  FrameBits    = 5'h10;
endpackage

// File: src/dgv_zero_detect.sv
// Run-length detector of consecutive zero samples for one channel
`timescale 1ns/1ps
module dgv_zero_detect (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic enable,
	input  wire logic sampleStrobe,
	input  wire logic sampleZero,
	output logic      zeroFlag
);
	logic [10:0] runCount_q;

	// Count zero samples; saturate at the run length so the flag holds
	always_ff @(posedge clock) begin
		if (sys_rst || !enable) begin
			runCount_q <= 11'h000;
		end else if (sampleStrobe) begin
			if (!sampleZero) begin
				runCount_q <= 11'h000;
			end else if (runCount_q != dgv_pkg::ZeroRunLen) begin
				runCount_q <= runCount_q + 11'h001;
			end
		end
	end

	assign zeroFlag = (runCount_q == dgv_pkg::ZeroRunLen);

	// Disabling clears the run at the next edge, so the flag may trail enable by that one cycle only
	a_zero_run_flag: assert property (@(posedge clock) disable iff (sys_rst)
		!enable |=> !zeroFlag)
		else $error("zero flag while detection disabled");
endmodule

// File: src/dgv_gain_volume_regs.sv
// Gain and volume register bank with serial control port and applied attenuation
`timescale 1ns/1ps
module dgv_gain_volume_regs (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic ctrlLatch,
	input  wire logic ctrlShift,
	input  wire logic ctrlData,
	input  wire logic sampleStrobe,
	input  wire logic leftSampleZero,
	input  wire logic rightSampleZero,
	input  wire logic [3:0] readIndex,
	output logic [8:0] readData,
	output logic [9:0] leftGainApplied,
	output logic [9:0] rightGainApplied,
	output logic       headroomCut,
	output logic       gradualSilence,
	output logic       analogSilence,
	output logic       zeroIndicatorPin,
	output logic       glideBusy,
	output logic [8:0] formatBits,
	output logic [8:0] filterBits,
	output logic [8:0] modeOneBits,
	output logic [8:0] modeTwoBits,
	output logic [8:0] addOneBits,
	output logic       softResetPulse
);
	// Serial shift state
	logic [15:0] shift_q;
	logic [4:0]  bitCount_q;
	logic        writeStb;
	logic [6:0]  wrAddr;
	logic [8:0]  wrData;

	// Register storage
	logic [4:0]  leftLow_q, leftHigh_q, rightLow_q, rightHigh_q;
	logic [8:0]  volume_q, format_q, filter_q, modeOne_q, modeTwo_q, addOne_q;
	logic        softReset_q;
	logic        applyPending_q;
	logic [9:0]  leftTarget_q, rightTarget_q;
	logic [9:0]  leftGain_q, rightGain_q;
	logic [9:0]  rightOut_q;
	logic        leftZero, rightZero, bitStream;
	logic        zeroPin_d;

	// One glide step towards the target; holds once the target is reached
	function automatic logic [9:0] glide_step(input logic [9:0] cur, input logic [9:0] tgt);
		if (cur < tgt) begin
			glide_step = cur + 10'h001;
		end else if (cur > tgt) begin
			glide_step = cur - 10'h001;
		end else begin
			glide_step = cur;
		end
	endfunction

	// Serial port: MSB first, 16 bits; latch high completes the frame
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shift_q    <= 16'h0000;
			bitCount_q <= 5'h00;
		end else if (ctrlLatch) begin
			bitCount_q <= 5'h00;
		end else if (ctrlShift) begin
			shift_q <= {shift_q[14:0], ctrlData};
			if (bitCount_q != dgv_pkg::FrameBits) begin
				bitCount_q <= bitCount_q + 5'h01;
			end
		end
	end

	// A frame counts with sixteen bits or more, the last sixteen kept; short frames are dropped
	assign writeStb = ctrlLatch && (bitCount_q == dgv_pkg::FrameBits);
	assign wrAddr   = shift_q[15:9];
	assign wrData   = shift_q[8:0];

	// Attenuation staging registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			leftLow_q   <= 5'h00;
			leftHigh_q  <= 5'h00;
			rightLow_q  <= 5'h00;
			rightHigh_q <= 5'h00;
		end else if (writeStb) begin
			unique case (wrAddr)
				dgv_pkg::OffLeftLow:   leftLow_q   <= wrData[4:0];
				dgv_pkg::OffLeftHigh:  leftHigh_q  <= wrData[4:0];
				dgv_pkg::OffRightLow:  rightLow_q  <= wrData[4:0];
				dgv_pkg::OffRightHigh: rightHigh_q <= wrData[4:0];
				default: ;
			endcase
		end
	end

	// Update request is taken one cycle later so the stored value is already in place
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			applyPending_q <= 1'b0;
		end else begin
			applyPending_q <= writeStb && (wrAddr <= dgv_pkg::OffRightHigh) && wrData[dgv_pkg::UpdateBit];
		end
	end

	// Targets take all four staging registers together
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			leftTarget_q  <= 10'h000;
			rightTarget_q <= 10'h000;
		end else if (applyPending_q) begin
			leftTarget_q  <= {leftHigh_q, leftLow_q};
			rightTarget_q <= {rightHigh_q, rightLow_q};
		end
	end

	// Applied gain glides one 0.125dB code per cycle, or jumps
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			leftGain_q  <= 10'h000;
			rightGain_q <= 10'h000;
		end else if (volume_q[dgv_pkg::GlideBit]) begin
			leftGain_q  <= glide_step(leftGain_q, leftTarget_q);
			rightGain_q <= glide_step(rightGain_q, rightTarget_q);
		end else begin
			leftGain_q  <= leftTarget_q;
			rightGain_q <= rightTarget_q;
		end
	end

	// Busy while either channel still glides; left combinational like a handshake level
	assign glideBusy = (leftGain_q != leftTarget_q) || (rightGain_q != rightTarget_q);

	// Right output picks its source in a register, so a follow-bit change never glitches the pin
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rightOut_q <= 10'h000;
		end else begin
			rightOut_q <= volume_q[dgv_pkg::FollowBit] ? leftGain_q : rightGain_q;
		end
	end

	// Remaining control registers; soft reset restores their defaults, but not the staging words, targets or gains
	always_ff @(posedge clock) begin
		if (sys_rst || softReset_q) begin
			volume_q  <= dgv_pkg::RstZero;
			format_q  <= dgv_pkg::RstFormat;
			filter_q  <= dgv_pkg::RstZero;
			modeOne_q <= dgv_pkg::RstZero;
			modeTwo_q <= dgv_pkg::RstModeTwo;
			addOne_q  <= dgv_pkg::RstZero;
		end else if (writeStb) begin
			unique case (wrAddr)
				dgv_pkg::OffVolume:  volume_q  <= wrData;
				dgv_pkg::OffFormat:  format_q  <= wrData;
				dgv_pkg::OffFilter:  filter_q  <= wrData;
				dgv_pkg::OffModeOne: modeOne_q <= wrData;
				dgv_pkg::OffModeTwo: modeTwo_q <= wrData;
				dgv_pkg::OffAddOne:  addOne_q  <= wrData;
				default: ;
			endcase
		end
	end

	// Write-only reset register yields a single-cycle pulse
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			softReset_q <= 1'b0;
		end else begin
			softReset_q <= writeStb && (wrAddr == dgv_pkg::OffSoftReset) && wrData[dgv_pkg::ResetBit];
		end
	end

	// Every code other than PCM, the unused one included, counts as bit-stream
	assign bitStream = (modeOne_q[1:0] != dgv_pkg::ModePcm);

	// Per-channel long zero detectors
	dgv_zero_detect uLeftZero (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.enable       (volume_q[dgv_pkg::DetectBit]),
		.sampleStrobe (sampleStrobe),
		.sampleZero   (leftSampleZero),
		.zeroFlag     (leftZero)
	);
	dgv_zero_detect uRightZero (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.enable       (volume_q[dgv_pkg::DetectBit]),
		.sampleStrobe (sampleStrobe),
		.sampleZero   (rightSampleZero),
		.zeroFlag     (rightZero)
	);

	// Zero pin source select; quiet in bit-stream mode
	always_comb begin
		unique case (volume_q[dgv_pkg::ZeroSrcLo +: 2])
			dgv_pkg::ZeroBoth:  zeroPin_d = leftZero && rightZero;
			dgv_pkg::ZeroLeft:  zeroPin_d = leftZero;
			dgv_pkg::ZeroRight: zeroPin_d = rightZero;
			dgv_pkg::ZeroOff:   zeroPin_d = 1'b0;
		endcase
		if (bitStream) begin
			zeroPin_d = 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			zeroIndicatorPin <= 1'b0;
			headroomCut      <= 1'b0;
			gradualSilence   <= 1'b0;
			analogSilence    <= 1'b0;
		end else begin
			zeroIndicatorPin <= zeroPin_d;
			headroomCut      <= volume_q[dgv_pkg::CutBit];
			gradualSilence   <= volume_q[dgv_pkg::SilenceBit];
			analogSilence    <= volume_q[dgv_pkg::AnalogBit] && bitStream;
		end
	end

	// Output pins; the right word lags the left by one edge, the price of a registered source
	assign leftGainApplied  = leftGain_q;
	assign rightGainApplied = rightOut_q;
	assign formatBits       = format_q;
	assign filterBits       = filter_q;
	assign modeOneBits      = modeOne_q;
	assign modeTwoBits      = modeTwo_q;
	assign addOneBits       = addOne_q;
	assign softResetPulse   = softReset_q;

	// Readback by register index; 10 stands for offset 20h
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			readData <= 9'h000;
		end else begin
			unique case (readIndex)
				4'h0: readData <= {4'h0, leftLow_q};
				4'h1: readData <= {4'h0, leftHigh_q};
				4'h2: readData <= {4'h0, rightLow_q};
				4'h3: readData <= {4'h0, rightHigh_q};
				4'h4: readData <= volume_q;
				4'h5: readData <= format_q;
				4'h6: readData <= filter_q;
				4'h7: readData <= modeOne_q;
				4'h8: readData <= modeTwo_q;
				4'ha: readData <= addOne_q;
				default: readData <= 9'h000;
			endcase
		end
	end

	// Each staging word takes the five low data bits of its own frame
	a_left_low_store: assert property (@(posedge clock) disable iff (sys_rst)
		(writeStb && wrAddr == dgv_pkg::OffLeftLow) |=> leftLow_q == $past(wrData[4:0]))
		else $error("left low word not stored");
	a_left_high_store: assert property (@(posedge clock) disable iff (sys_rst)
		(writeStb && wrAddr == dgv_pkg::OffLeftHigh) |=> leftHigh_q == $past(wrData[4:0]))
		else $error("left high word not stored");
	a_right_low_store: assert property (@(posedge clock) disable iff (sys_rst)
		(writeStb && wrAddr == dgv_pkg::OffRightLow) |=> rightLow_q == $past(wrData[4:0]))
		else $error("right low word not stored");
	a_right_high_store: assert property (@(posedge clock) disable iff (sys_rst)
		(writeStb && wrAddr == dgv_pkg::OffRightHigh) |=> rightHigh_q == $past(wrData[4:0]))
		else $error("right high word not stored");

	// Targets move only on an update request, and then take all four words
	a_stage_no_apply: assert property (@(posedge clock) disable iff (sys_rst)
		(writeStb && wrAddr <= dgv_pkg::OffRightHigh && !wrData[dgv_pkg::UpdateBit])
		|=> ##1 $stable(leftTarget_q) && $stable(rightTarget_q))
		else $error("target changed without update bit");
	a_update_apply: assert property (@(posedge clock) disable iff (sys_rst)
		applyPending_q |=> leftTarget_q == {leftHigh_q, leftLow_q})
		else $error("update did not apply left words");
	a_update_right: assert property (@(posedge clock) disable iff (sys_rst)
		applyPending_q |=> rightTarget_q == {rightHigh_q, rightLow_q})
		else $error("update did not apply right words");

	// Step mode copies the target in one edge; glide mode moves one code per edge towards it
	a_step_change: assert property (@(posedge clock) disable iff (sys_rst)
		!volume_q[dgv_pkg::GlideBit] |=> leftGain_q == $past(leftTarget_q))
		else $error("step change missed");
	a_glide_step: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::GlideBit] && leftGain_q < leftTarget_q)
		|=> leftGain_q == $past(leftGain_q) + 10'h001)
		else $error("glide step wrong");
	a_glide_down: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::GlideBit] && leftGain_q > leftTarget_q)
		|=> leftGain_q == $past(leftGain_q) - 10'h001)
		else $error("glide down step wrong");
	a_glide_right_up: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::GlideBit] && rightGain_q < rightTarget_q)
		|=> rightGain_q == $past(rightGain_q) + 10'h001)
		else $error("right glide step wrong");
	a_glide_right_down: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::GlideBit] && rightGain_q > rightTarget_q)
		|=> rightGain_q == $past(rightGain_q) - 10'h001)
		else $error("right glide down step wrong");

	// Level outputs trail their control bits by one edge; the right pin trails the left word by one
	a_cut_follow: assert property (@(posedge clock) disable iff (sys_rst)
		##1 headroomCut == $past(volume_q[dgv_pkg::CutBit]))
		else $error("headroom cut not following");
	a_right_follow: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::FollowBit] && !volume_q[dgv_pkg::GlideBit]) ##1 volume_q[dgv_pkg::FollowBit]
		|=> rightGainApplied == $past(leftTarget_q, 2))
		else $error("right not following left");
	a_silence_follow: assert property (@(posedge clock) disable iff (sys_rst)
		##1 gradualSilence == $past(volume_q[dgv_pkg::SilenceBit]))
		else $error("soft mute not following");

	// Zero pin: detectors clear when disabled, source select in PCM, quiet in bit-stream
	a_detect_off: assert property (@(posedge clock) disable iff (sys_rst)
		!volume_q[dgv_pkg::DetectBit] |=> !leftZero && !rightZero)
		else $error("zero run kept while detection disabled");
	a_zero_pin_and: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::ZeroSrcLo +: 2] == dgv_pkg::ZeroBoth && !bitStream)
		|=> zeroIndicatorPin == $past(leftZero && rightZero))
		else $error("zero pin AND wrong");
	a_zero_pin_left: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::ZeroSrcLo +: 2] == dgv_pkg::ZeroLeft && !bitStream)
		|=> zeroIndicatorPin == $past(leftZero))
		else $error("zero pin left source wrong");
	a_zero_pin_right: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::ZeroSrcLo +: 2] == dgv_pkg::ZeroRight && !bitStream)
		|=> zeroIndicatorPin == $past(rightZero))
		else $error("zero pin right source wrong");
	a_zero_pin_off: assert property (@(posedge clock) disable iff (sys_rst)
		volume_q[dgv_pkg::ZeroSrcLo +: 2] == dgv_pkg::ZeroOff |=> !zeroIndicatorPin)
		else $error("zero pin active while disabled");
	a_zero_bitstream: assert property (@(posedge clock) disable iff (sys_rst)
		bitStream |=> !zeroIndicatorPin)
		else $error("zero pin active in bit-stream");

	// Analogue mute only with its bit set in bit-stream mode
	a_analog_pcm: assert property (@(posedge clock) disable iff (sys_rst)
		analogSilence |-> $past(bitStream))
		else $error("analog mute outside bit-stream");
	a_analog_apply: assert property (@(posedge clock) disable iff (sys_rst)
		(volume_q[dgv_pkg::AnalogBit] && bitStream) |=> analogSilence)
		else $error("analog mute not applied");
endmodule

// File: bench/dgv_host_model.sv
// Host controller model driving frames onto the serial control port
`timescale 1ns/1ps
module dgv_host_model (
	input  wire logic clock,
	output logic      ctrlLatch,
	output logic      ctrlShift,
	output logic      ctrlData
);
	initial begin
		ctrlLatch = 1'b0;
		ctrlShift = 1'b0;
		ctrlData  = 1'b0;
	end
	// Sixteen bits MSB first, then the latch; a released data line shows the inverse, never a stale bit
	task automatic send(input logic [6:0] addr, input logic [8:0] data);
		logic [15:0] frame;
		frame = {addr, data};
		for (int i = 15; i >= 0; i--) begin
			@(posedge clock) #1;
			ctrlShift = 1'b1;
			ctrlData  = frame[i];
		end
		@(posedge clock) #1;
		ctrlShift = 1'b0;
		ctrlLatch = 1'b1;
		ctrlData  = ~frame[0];
		@(posedge clock) #1;
		ctrlLatch = 1'b0;
	endtask
endmodule

// File: bench/dgv_gain_volume_regs_tb.sv
// Self-checking bench for the gain and volume register bank
`timescale 1ns/1ps
module dgv_gain_volume_regs_tb;
	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ctrlLatch, ctrlShift, ctrlData;
	logic       sampleStrobe = 1'b0;
	logic       leftSampleZero = 1'b0;
	logic       rightSampleZero = 1'b0;
	logic [3:0] readIndex = 4'h0;
	logic [8:0] readData, formatBits, modeTwoBits, filterBits, modeOneBits, addOneBits;
	logic [9:0] leftGainApplied, rightGainApplied;
	logic       headroomCut, gradualSilence, analogSilence, zeroIndicatorPin, glideBusy, softResetPulse;
	int         regs [11];
	int         appL, appR, err_count, checked, n;
	logic [4:0] lo, hi;

	// Free-running 50 MHz clock
	always #10 clock = ~clock;

	dgv_host_model host (.clock(clock), .ctrlLatch(ctrlLatch), .ctrlShift(ctrlShift), .ctrlData(ctrlData));

	dgv_gain_volume_regs uut (.clock(clock), .sys_rst(sys_rst), .ctrlLatch(ctrlLatch), .ctrlShift(ctrlShift),
		.ctrlData(ctrlData), .sampleStrobe(sampleStrobe), .leftSampleZero(leftSampleZero),
		.rightSampleZero(rightSampleZero), .readIndex(readIndex), .readData(readData),
		.leftGainApplied(leftGainApplied), .rightGainApplied(rightGainApplied), .headroomCut(headroomCut),
		.gradualSilence(gradualSilence), .analogSilence(analogSilence), .zeroIndicatorPin(zeroIndicatorPin),
		.glideBusy(glideBusy), .formatBits(formatBits), .filterBits(filterBits), .modeOneBits(modeOneBits),
		.modeTwoBits(modeTwoBits), .addOneBits(addOneBits), .softResetPulse(softResetPulse));

	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask

	// Frame write plus the reference model of staging and apply
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		host.send(a, d);
		regs[a == 7'h20 ? 10 : a] = d;
		if (a < 7'h04 && d[5]) begin
			appL = {regs[1][4:0], regs[0][4:0]};
			appR = {regs[3][4:0], regs[2][4:0]};
		end
		tick(4);
	endtask

	task automatic rd(input int i, input logic [8:0] m);
		readIndex = 4'(i);
		tick(2);
		chk("readData", 10'(regs[i]) & {1'b0, m}, {1'b0, readData & m});
	endtask

	task automatic final_report;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		regs = '{default: 0};
		regs[5] = 9'h00a;
		regs[8] = 9'h002;
		void'($urandom(21));
		tick(4);
		sys_rst = 1'b0;
		for (int i = 0; i < 11; i++) if (i != 9) rd(i, 9'h1ff);
		chk("formatBits", 10'h00a, formatBits);
		chk("modeTwoBits", 10'h002, modeTwoBits);
		$display("reset test done");
		// Stage three parts, apply with the fourth
		lo = 5'($urandom_range(31, 0));
		hi = 5'($urandom_range(31, 0)) | 5'h01;
		wr(7'h00, {4'h0, lo});
		chk("leftGainApplied", 10'h000, leftGainApplied);
		rd(0, 9'h01f);
		wr(7'h02, {4'h0, 5'($urandom_range(31, 0))});
		wr(7'h03, {4'h0, 5'($urandom_range(31, 0))});
		chk("rightGainApplied", 10'h000, rightGainApplied);
		wr(7'h01, {4'h1, hi});
		chk("leftGainApplied", 10'(appL), leftGainApplied);
		chk("rightGainApplied", 10'(appR), rightGainApplied);
		wr(7'h04, 9'h004);
		chk("rightGainApplied", 10'(appL), rightGainApplied);
		wr(7'h04, 9'h001);
		chk("rightGainApplied", 10'(appR), rightGainApplied);
		$display("attenuation test done");
		// Ramp across at least 512 codes
		wr(7'h01, {4'h1, hi ^ 5'h10});
		chk("glideBusy", 10'h001, glideBusy);
		n = 0;
		while (glideBusy !== 1'b0 && n < 1100) begin
			tick(1);
			n++;
		end
		if (n >= 1100) begin
			err_count++;
			final_report();
		end
		chk("leftGainApplied", 10'(appL), leftGainApplied);
		$display("glide test done");
		wr(7'h04, 9'h002);
		chk("headroomCut", 10'h001, headroomCut);
		chk("gradualSilence", 10'h000, gradualSilence);
		wr(7'h04, 9'h008);
		chk("gradualSilence", 10'h001, gradualSilence);
		chk("headroomCut", 10'h000, headroomCut);
		wr(7'h04, 9'h080);
		chk("analogSilence", 10'h000, analogSilence);
		wr(7'h07, 9'h001);
		chk("analogSilence", 10'h001, analogSilence);
		wr(7'h07, 9'h000);
		rd(4, 9'h1ff);
		$display("volume test done");
		// Left samples zero, right samples not
		wr(7'h04, 9'h030);
		leftSampleZero = 1'b1;
		sampleStrobe = 1'b1;
		tick(1023);
		sampleStrobe = 1'b0;
		tick(3);
		chk("zeroIndicatorPin", 10'h000, zeroIndicatorPin);
		sampleStrobe = 1'b1;
		tick(1);
		sampleStrobe = 1'b0;
		tick(3);
		chk("zeroIndicatorPin", 10'h001, zeroIndicatorPin);
		for (int c = 0; c < 4; c++) begin
			wr(7'h04, {2'h0, 2'(c), 5'h10});
			chk("zeroIndicatorPin", 10'(c == 1), zeroIndicatorPin);
		end
		// Right run reaches its length too, so every source but the off code shows a zero
		rightSampleZero = 1'b1;
		sampleStrobe = 1'b1;
		tick(1024);
		sampleStrobe = 1'b0;
		for (int c = 0; c < 4; c++) begin
			wr(7'h04, {2'h0, 2'(c), 5'h10});
			chk("zeroIndicatorPin", 10'(c != 3), zeroIndicatorPin);
		end
		wr(7'h04, 9'h030);
		wr(7'h07, 9'h001);
		chk("zeroIndicatorPin", 10'h000, zeroIndicatorPin);
		wr(7'h07, 9'h000);
		wr(7'h04, 9'h020);
		chk("zeroIndicatorPin", 10'h000, zeroIndicatorPin);
		$display("zero test done");
		// Spare registers take words, then a soft reset restores control defaults but not staging
		wr(7'h06, 9'($urandom_range(511, 0)));
		wr(7'h07, 9'h004);
		wr(7'h20, 9'($urandom_range(511, 0)));
		chk("filterBits", 10'(regs[6]), filterBits);
		chk("modeOneBits", 10'(regs[7]), modeOneBits);
		chk("addOneBits", 10'(regs[10]), addOneBits);
		host.send(7'h09, 9'h100);
		chk("softResetPulse", 10'h001, softResetPulse);
		tick(1);
		chk("softResetPulse", 10'h000, softResetPulse);
		for (int i = 4; i < 11; i++) regs[i] = 0;
		regs[5] = 9'h00a;
		regs[8] = 9'h002;
		for (int i = 0; i < 11; i++) if (i != 9) rd(i, i < 4 ? 9'h01f : 9'h1ff);
		chk("addOneBits", 10'h000, addOneBits);
		$display("soft reset test done");
		final_report();
	end
endmodule
